/* File: phl_pkg.sv */
// Shared constants and types for the link pulse and MII latency block
package phl_pkg;
   // Reference clock
   localparam int CLK_PERIOD_NS = 40;
   // Fast link pulse timing
   localparam int FLP_WIDTH_NS = 100;
   localparam int FLP_WIDTH_CYC = (FLP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLP_CLK_SPACING_NS = 125000;
   localparam int FLP_CLK_SPACING_CYC = FLP_CLK_SPACING_NS / CLK_PERIOD_NS;
   localparam int FLP_DATA_OFS_PS = 62500000;
   localparam int FLP_DATA_OFS_CYC = (FLP_DATA_OFS_PS / 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FLP_DATA_BITS = 16;
   localparam int FLP_MIN_PULSES = 17;
   localparam int FLP_MAX_PULSES = 33;
   localparam int BURST_PERIOD_NS = 16000000;
   localparam int BURST_PERIOD_CYC_DEF = BURST_PERIOD_NS / CLK_PERIOD_NS;
   // MII receive clock periods
   localparam int RX_PERIOD_100_NS = 40;
   localparam int RX_PERIOD_10_NS = 400;
   localparam int RX_DIV_100 = RX_PERIOD_100_NS / CLK_PERIOD_NS;
   localparam int RX_DIV_10 = RX_PERIOD_10_NS / CLK_PERIOD_NS;
   // Transmit latency from sampled enable to line
   localparam int TX_LAT_100_NS = 60;
   localparam int TX_LAT_10_NS = 400;
   localparam int TX_LAT_100_CYC = (TX_LAT_100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TX_LAT_10_CYC = TX_LAT_10_NS / CLK_PERIOD_NS;
   // Nibble width
   localparam int NIB_W = 4;
   // Link pulse sequencer states
   typedef enum logic [2:0] {
      LP_WAIT = 3'b001,
      LP_BURST = 3'b010,
      LP_NLP = 3'b100
   } phl_lp_state_type;
endpackage

/* File: phl_buf_if.sv */
// Valid/ready carrier between the receive path and its buffer
`timescale 1ns/1ps
interface phl_buf_if #(
   parameter int W = 4
);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport src (
      output in_valid,
      output in_data,
      input in_ready,
      input out_valid,
      input out_data,
      output out_ready
   );
   modport fifo (
      input in_valid,
      input in_data,
      output in_ready,
      output out_valid,
      output out_data,
      input out_ready
   );
endinterface

/* File: phl_buf.sv */
// Small register buffer with valid/ready on both sides
`timescale 1ns/1ps
module phl_buf #(
   parameter int W = 4,
   parameter int DEPTH = 2
) (
   // Clock and control
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   // Data path
   phl_buf_if.fifo bi
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } phl_buf_state_type;

   phl_buf_state_type s_r;
   phl_buf_state_type s_nxt;
   logic push;
   logic pop;

   assign bi.in_ready = (s_r.cnt != CNT_FULL);
   assign bi.out_valid = (s_r.cnt != '0);
   assign bi.out_data = s_r.mem[s_r.rp];
   assign push = bi.in_valid && bi.in_ready;
   assign pop = bi.out_valid && bi.out_ready;

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = bi.in_data;
         s_nxt.wp = (s_r.wp == PTR_LAST) ? '0 : s_r.wp + 1'b1;
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == PTR_LAST) ? '0 : s_r.rp + 1'b1;
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_r <= '0;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end
endmodule

/* File: phl_top.sv */
// Link pulse generator and MII carrier, receive and transmit latency logic
//
// Contract
// - Clock pulses of a fast link pulse burst are 125 us apart and each is about 100 ns wide.
// - A one bit of the link code word puts a data pulse 62.5 us after its clock pulse.
// - A burst holds 17 to 33 pulses and lasts about 2 ms.
// - Bursts repeat every 16 ms nominally, within 8 to 24 ms.
// - The receive clock toward the MAC has a 40 ns period at 100 Mbit/s and 400 ns at 10 Mbit/s.
// - Carrier sense rises within 250 ns (100M) or 3.5 us (10M) after a received frame starts.
// - Receive data valid is shown at a sampling edge within 300 ns (100M) or 4 us (10M) of frame start.
// - Receive data valid drops at a sampling edge within 200 ns (100M) or 1 us (10M) after frame end.
// - Carrier sense drops within 300 ns (100M) or 1 us (10M) after a received frame ends.
// - Carrier sense rises within 40 ns (100M) or 4 us (10M) of transmit enable sampled high.
// - Carrier sense drops within 160 ns (100M) or about 1 us (10M) of transmit enable sampled low.
// - Transmit data reaches the line 60 to 140 ns (100M) or about 400 ns (10M) after enable is sampled.
// - The line frame ends within 170 ns (100M) or 500 ns (10M) after enable is sampled low.
// - At 10 Mbit/s without negotiation single 100 ns link pulses repeat every 8 to 24 ms.
`timescale 1ns/1ps
module phl_top #(
   parameter int BURST_PERIOD_CYC = phl_pkg::BURST_PERIOD_CYC_DEF
) (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   // Configuration
   input wire logic speed_100_pin,
   input wire logic an_enable,
   input wire logic [15:0] link_code_word,
   // Line receive side
   input wire logic line_clk,
   input wire logic line_frame,
   input wire logic [3:0] line_data,
   // MAC transmit side
   input wire logic tx_en,
   input wire logic [3:0] txd,
   // Line outputs
   output logic link_pulse,
   output logic tx_line_en,
   output logic [3:0] tx_line_d,
   // MAC receive side
   output logic crs,
   output logic rx_clk_stb,
   output logic rx_dv,
   output logic [3:0] rxd
);
   localparam int NW = phl_pkg::NIB_W;
   localparam int PW = $clog2(BURST_PERIOD_CYC + 1);
   localparam int TXD = phl_pkg::TX_LAT_10_CYC;
   localparam logic [PW-1:0] PER_LAST = PW'(BURST_PERIOD_CYC - 1);
   localparam logic [11:0] TMR_CLK_LAST = 12'(phl_pkg::FLP_CLK_SPACING_CYC - 1);
   localparam logic [11:0] TMR_PW = 12'(phl_pkg::FLP_WIDTH_CYC);
   localparam logic [11:0] TMR_DOFS = 12'(phl_pkg::FLP_DATA_OFS_CYC);
   localparam logic [4:0] SLOT_LAST = 5'(phl_pkg::FLP_DATA_BITS);
   localparam logic [3:0] RX_RELOAD_100 = 4'(phl_pkg::RX_DIV_100 - 1);
   localparam logic [3:0] RX_RELOAD_10 = 4'(phl_pkg::RX_DIV_10 - 1);
   // Shift stage and output register each add a cycle to the tap
   localparam logic [3:0] TAP_100 = 4'(phl_pkg::TX_LAT_100_CYC - 2);
   localparam logic [3:0] TAP_10 = 4'(phl_pkg::TX_LAT_10_CYC - 2);

   typedef struct packed {
      logic spd_meta;
      logic spd_s;
      logic lclk_meta;
      logic lclk_s;
      logic lclk_d;
      logic lfrm_meta;
      logic lfrm_s;
      logic [NW-1:0] ldat_meta;
      logic [NW-1:0] ldat_s;
      logic txen_meta;
      logic txen_s;
      logic [NW-1:0] txd_meta;
      logic [NW-1:0] txd_s;
      logic [TXD-1:0][NW:0] txsh;
      phl_pkg::phl_lp_state_type phase;
      logic [PW-1:0] per_cnt;
      logic [4:0] slot;
      logic [11:0] tmr;
      logic lp_r;
      logic crs_r;
      logic [3:0] rx_div;
      logic rx_stb_r;
      logic rxdv_r;
      logic [NW-1:0] rxd_r;
      logic tx_en_r;
      logic [NW-1:0] tx_d_r;
      logic cap_vld;
      logic [NW-1:0] cap_d;
   } phl_state_type;

   phl_state_type s_r;
   phl_state_type s_nxt;
   logic lrise;
   logic rx_tick;
   logic data_bit;
   logic [3:0] tap;

   phl_buf_if #(.W(NW)) bi ();

   phl_buf #(
      .W(NW),
      .DEPTH(2)
   ) u_buf (
      .clock(clock),
      .resetn(resetn),
      .clk_en(clk_en),
      .bi(bi)
   );

   assign lrise = s_r.lclk_s && !s_r.lclk_d;
   assign rx_tick = (s_r.rx_div == 4'h0);
   assign data_bit = (s_r.slot < SLOT_LAST) ? link_code_word[s_r.slot[3:0]] : 1'b0;
   assign tap = s_r.spd_s ? TAP_100 : TAP_10;
   assign bi.in_valid = s_r.cap_vld;
   assign bi.in_data = s_r.cap_d;
   assign bi.out_ready = rx_tick;

   always_comb begin
      s_nxt = s_r;
      // Two-flop synchronisers for the speed, line and transmit inputs; an_enable and link_code_word are used directly
      s_nxt.spd_meta = speed_100_pin;
      s_nxt.spd_s = s_r.spd_meta;
      s_nxt.lclk_meta = line_clk;
      s_nxt.lclk_s = s_r.lclk_meta;
      s_nxt.lclk_d = s_r.lclk_s;
      s_nxt.lfrm_meta = line_frame;
      s_nxt.lfrm_s = s_r.lfrm_meta;
      s_nxt.ldat_meta = line_data;
      s_nxt.ldat_s = s_r.ldat_meta;
      s_nxt.txen_meta = tx_en;
      s_nxt.txen_s = s_r.txen_meta;
      s_nxt.txd_meta = txd;
      s_nxt.txd_s = s_r.txd_meta;

      s_nxt.per_cnt = (s_r.per_cnt == PER_LAST) ? '0 : s_r.per_cnt + 1'b1;
      s_nxt.lp_r = 1'b0;
      unique case (s_r.phase)
         phl_pkg::LP_WAIT: begin
            if (s_r.per_cnt == PER_LAST) begin
               s_nxt.tmr = '0;
               s_nxt.slot = '0;
               if (an_enable) begin
                  s_nxt.phase = phl_pkg::LP_BURST;
               end else if (!s_r.spd_s) begin
                  s_nxt.phase = phl_pkg::LP_NLP;
               end
            end
         end
         phl_pkg::LP_BURST: begin
            s_nxt.lp_r = (s_r.tmr < TMR_PW);
            if (data_bit && s_r.tmr >= TMR_DOFS && s_r.tmr < TMR_DOFS + TMR_PW) begin
               s_nxt.lp_r = 1'b1;
            end
            s_nxt.tmr = s_r.tmr + 1'b1;
            // seventeen clock slots end the burst
            if (s_r.slot == SLOT_LAST && s_r.tmr == TMR_PW - 1'b1) begin
               s_nxt.phase = phl_pkg::LP_WAIT;
            end else if (s_r.tmr == TMR_CLK_LAST) begin
               s_nxt.tmr = '0;
               s_nxt.slot = s_r.slot + 1'b1;
            end
         end
         phl_pkg::LP_NLP: begin
            s_nxt.lp_r = 1'b1;
            s_nxt.tmr = s_r.tmr + 1'b1;
            if (s_r.tmr == TMR_PW - 1'b1) begin
               s_nxt.phase = phl_pkg::LP_WAIT;
            end
         end
         default: begin
            s_nxt.phase = phl_pkg::LP_WAIT;
         end
      endcase

      // carrier from line frame or transmit enable
      s_nxt.crs_r = s_r.lfrm_s || s_r.txen_s;

      s_nxt.txsh = {s_r.txsh[TXD-2:0], {s_r.txen_s, s_r.txd_s}};
      s_nxt.tx_en_r = s_r.txsh[tap][NW];
      s_nxt.tx_d_r = s_r.txsh[tap][NW-1:0];

      // Capture a line nibble; a full buffer stalls the capture stage
      if (bi.in_ready) begin
         s_nxt.cap_vld = 1'b0;
      end
      if (lrise && s_r.lfrm_s && !(s_r.cap_vld && !bi.in_ready)) begin
         s_nxt.cap_vld = 1'b1;
         s_nxt.cap_d = s_r.ldat_s;
      end

      // receive clock edges from the reference clock
      s_nxt.rx_stb_r = rx_tick;
      if (rx_tick) begin
         s_nxt.rx_div = s_r.spd_s ? RX_RELOAD_100 : RX_RELOAD_10;
         s_nxt.rxdv_r = bi.out_valid || s_r.lfrm_s;
         if (bi.out_valid) begin
            s_nxt.rxd_r = bi.out_data;
         end else if (!s_r.lfrm_s) begin
            s_nxt.rxd_r = '0;
         end
      end else begin
         s_nxt.rx_div = s_r.rx_div - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.phase <= phl_pkg::LP_WAIT;
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   assign link_pulse = s_r.lp_r;
   assign tx_line_en = s_r.tx_en_r;
   assign tx_line_d = s_r.tx_d_r;
   assign crs = s_r.crs_r;
   assign rx_clk_stb = s_r.rx_stb_r;
   assign rx_dv = s_r.rxdv_r;
   assign rxd = s_r.rxd_r;

   // Pulses counted in the current burst, for checking only
   logic [5:0] pcnt;
   logic lp_q;
   logic in_burst;
   assign in_burst = (s_r.phase == phl_pkg::LP_BURST);
   always_ff @(posedge clock) begin
      if (!resetn) begin
         pcnt <= '0;
         lp_q <= 1'b0;
      end else if (clk_en) begin
         lp_q <= s_r.lp_r;
         if (s_nxt.phase == phl_pkg::LP_BURST && !in_burst) begin
            pcnt <= '0;
         end else if (s_r.lp_r && !lp_q) begin
            pcnt <= pcnt + 1'b1;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn || !clk_en);

   AST_PULSE_WIDTH: assert property ($rose(link_pulse) |-> link_pulse [*3] ##1 !link_pulse)
      else $error("link pulse width wrong");
   AST_CLK_SPACING: assert property (in_burst && s_r.tmr == TMR_CLK_LAST |-> ##2 link_pulse)
      else $error("clock pulse missing at slot boundary");
   AST_DATA_PULSE: assert property (in_burst && s_r.tmr == TMR_DOFS |=> (link_pulse == $past(data_bit)))
      else $error("data pulse does not match code word bit");
   AST_BURST_COUNT: assert property ($fell(in_burst) |-> ##1 (pcnt >= 6'd17 && pcnt <= 6'd33))
      else $error("pulse count per burst out of range");
   AST_PERIOD_BOUND: assert property (s_r.phase == phl_pkg::LP_WAIT && s_r.per_cnt == PER_LAST && an_enable |=> in_burst)
      else $error("burst not started at period end");
   AST_RX_CLK_10: assert property (rx_clk_stb && !s_r.spd_s && $stable(s_r.spd_s) |=> !rx_clk_stb [*8])
      else $error("receive clock too fast at 10M");
   AST_RX_CLK_100: assert property (rx_clk_stb && $past(s_r.spd_s) |=> rx_clk_stb)
      else $error("receive clock missing edge at 100M");
   AST_CRS_RISE: assert property ((s_r.lfrm_s || s_r.txen_s) |=> crs)
      else $error("carrier sense late");
   AST_CRS_FALL: assert property (!s_r.lfrm_s && !s_r.txen_s |=> !crs)
      else $error("carrier sense not dropped");
   AST_TX_LAT_100: assert property ($rose(s_r.txen_s) && s_r.spd_s && $stable(s_r.spd_s) |-> ##2 tx_line_en)
      else $error("transmit latency wrong at 100M");
   AST_RXDV_START: assert property ($rose(s_r.lfrm_s) && s_r.spd_s |-> ##[1:2] rx_dv)
      else $error("receive data valid late");

   COV_BURST: cover property ($fell(in_burst));
   COV_NLP: cover property (s_r.phase == phl_pkg::LP_NLP);
   COV_RX_FRAME: cover property ($fell(s_r.lfrm_s) ##[1:20] $fell(rx_dv));
   COV_TX_FRAME: cover property ($fell(tx_line_en));
endmodule

/* File: phl_mac_model.sv */
// Behavioural MAC on the far side of the MII
`timescale 1ns/1ps
module phl_mac_model (
   // Clock
   input wire logic clock,
   // Receive from the device
   input wire logic rx_clk_stb,
   input wire logic rx_dv,
   input wire logic [3:0] rxd,
   // Transmit toward the device
   output logic tx_en,
   output logic [3:0] txd
);
   logic [3:0] rxq[$];
   logic [3:0] last_rxd = 4'h0;
   initial begin
      tx_en = 1'b0;
      txd = 4'h0;
   end
   // Sample at each receive tick; a nibble counts when it differs from the last one shown,
   // since the device holds a stale nibble with data valid high during line gaps
   always @(posedge clock) begin
      if (rx_clk_stb === 1'b1) begin
         if (rx_dv === 1'b1 && rxd !== last_rxd) begin
            rxq.push_back(rxd);
         end
         last_rxd = rxd;
      end
   end
   // One nibble per transmit clock period of div cycles, low nibble first
   task automatic send(input logic [23:0] w, input int n, input int div);
      for (int i = 0; i < n; i++) begin
         @(negedge clock);
         tx_en = 1'b1;
         txd = w[4*i +: 4];
         repeat (div - 1) @(negedge clock);
      end
      @(negedge clock);
      tx_en = 1'b0;
      txd = ~txd;
   endtask
endmodule

/* File: phl_top_tb_top.sv */
// Self-checking bench for the link pulse and MII latency block
`timescale 1ns/1ps
module phl_top_tb_top;
   localparam int BP = 8000;
   localparam int SP = phl_pkg::FLP_CLK_SPACING_CYC;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic speed_100_pin = 1'b0;
   logic an_enable = 1'b0;
   logic [15:0] code = 16'h8005;
   logic line_clk = 1'b0;
   logic line_frame = 1'b0;
   logic [3:0] line_data = 4'h0;
   logic tx_en, link_pulse, tx_line_en, crs, rx_clk_stb, rx_dv;
   logic [3:0] txd, tx_line_d, rxd;
   logic [5:0] mv;
   logic [5:0] mq = 6'h0;
   logic [3:0] txq[$];
   int lp[$];
   int up[6];
   int dn[6];
   int cyc = 0;
   int stb_last = 0;
   int stb_gap = 0;
   int err_total = 0;
   int samples_checked = 0;
   phl_top #(.BURST_PERIOD_CYC(BP)) DUT (.clock(clock), .resetn(resetn), .clk_en(clk_en),
      .speed_100_pin(speed_100_pin), .an_enable(an_enable), .link_code_word(code), .line_clk(line_clk),
      .line_frame(line_frame), .line_data(line_data), .tx_en(tx_en), .txd(txd), .link_pulse(link_pulse),
      .tx_line_en(tx_line_en), .tx_line_d(tx_line_d), .crs(crs), .rx_clk_stb(rx_clk_stb), .rx_dv(rx_dv),
      .rxd(rxd));
   phl_mac_model mac (.clock(clock), .rx_clk_stb(rx_clk_stb), .rx_dv(rx_dv), .rxd(rxd), .tx_en(tx_en),
      .txd(txd));
   assign mv = {link_pulse, tx_line_en, rx_dv, crs, tx_en, line_frame};
   initial begin
      forever #20 clock = ~clock;
   end
   // Edge stamps in clock cycles for inputs and outputs
   always @(posedge clock) begin
      cyc = cyc + 1;
      for (int i = 0; i < 6; i++) begin
         if (mv[i] === 1'b1 && mq[i] !== 1'b1) up[i] = cyc;
         if (mv[i] === 1'b0 && mq[i] === 1'b1) dn[i] = cyc;
      end
      if (mv[5] === 1'b1 && mq[5] !== 1'b1) lp.push_back(cyc);
      if (rx_clk_stb === 1'b1) begin
         stb_gap = cyc - stb_last;
         stb_last = cyc;
      end
      if (tx_line_en === 1'b1 && (mq[4] !== 1'b1 || tx_line_d !== txq[$])) txq.push_back(tx_line_d);
      mq = mv;
   end
   task automatic chk_eq(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("unexpected %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
      samples_checked++;
      if (g < lo || g > hi) begin
         err_total++;
         $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic settle(input logic spd);
      @(negedge clock);
      speed_100_pin = spd;
      repeat (10) @(negedge clock);
   endtask
   task automatic line_send(input logic [23:0] w, input int n);
      @(negedge clock);
      line_frame = 1'b1;
      for (int i = 0; i < n; i++) begin
         line_data = w[4*i +: 4];
         repeat (4) @(negedge clock);
         line_clk = 1'b1;
         repeat (4) @(negedge clock);
         line_clk = 1'b0;
      end
      repeat (4) @(negedge clock);
      line_frame = 1'b0;
      line_data = ~line_data;
   endtask
   task automatic t_rxclk();
      for (int s = 1; s >= 0; s--) begin
         settle(s[0]);
         repeat (20) @(negedge clock);
         chk_eq("rx tick gap", s ? phl_pkg::RX_DIV_100 : phl_pkg::RX_DIV_10, stb_gap);
      end
      $display("test rx clock done");
   endtask
   task automatic t_rx(input logic spd);
      int n;
      settle(spd);
      // A 320 ns line clock outruns the 400 ns drain at 10M; keep that backlog short
      n = spd ? 6 : 4;
      mac.rxq.delete();
      line_send(24'h5a3c96, n);
      repeat (40) @(negedge clock);
      chk_rng("crs rise", 0, spd ? 6 : 87, up[2] - up[0]);
      chk_rng("dv rise", 0, spd ? 7 : 100, up[3] - up[0]);
      chk_rng("dv fall", 0, spd ? 5 : 25, dn[3] - dn[0]);
      chk_rng("crs fall", 0, spd ? 7 : 25, dn[2] - dn[0]);
      chk_eq("rx count", n, mac.rxq.size());
      for (int i = 0; i < n; i++) chk_eq("rxd", 24'h5a3c96 >> (4 * i) & 4'hf, mac.rxq[i]);
      $display("test receive done");
   endtask
   task automatic t_tx(input logic spd);
      settle(spd);
      txq.delete();
      mac.send(24'h7e2d4b, 6, spd ? 1 : 10);
      repeat (30) @(negedge clock);
      chk_rng("crs tx rise", 0, spd ? 1 : 100, up[2] - up[1] - 2);
      chk_rng("crs tx fall", 0, spd ? 4 : 25, dn[2] - dn[1] - 2);
      chk_rng("tx latency", spd ? phl_pkg::TX_LAT_100_CYC : phl_pkg::TX_LAT_10_CYC, spd ? 3 : 10, up[4] - up[1] - 2);
      chk_rng("tx end", 0, spd ? 4 : 12, dn[4] - dn[1] - 2);
      chk_eq("tx count", 6, txq.size());
      for (int i = 0; i < 6; i++) chk_eq("tx nibble", 24'h7e2d4b >> (4 * i) & 4'hf, txq[i]);
      $display("test transmit done");
   endtask
   task automatic t_nlp();
      int n0;
      settle(1'b0);
      n0 = lp.size();
      for (int i = 0; i < 2 * BP + 50 && lp.size() < n0 + 2; i++) @(negedge clock);
      repeat (5) @(negedge clock);
      chk_eq("nlp period", BP, lp[n0 + 1] - lp[n0]);
      chk_eq("nlp width", phl_pkg::FLP_WIDTH_CYC, dn[5] - up[5]);
      $display("test normal link pulse done");
   endtask
   task automatic t_flp();
      int n0;
      int r;
      settle(1'b1);
      an_enable = 1'b1;
      n0 = lp.size();
      for (int i = 0; i < BP + 50 && lp.size() <= n0; i++) @(negedge clock);
      repeat (16 * SP + 20) @(negedge clock);
      an_enable = 1'b0;
      r = lp[n0];
      chk_eq("data offset", phl_pkg::FLP_DATA_OFS_CYC, lp[n0 + 1] - r);
      chk_eq("clock spacing", SP, lp[n0 + 2] - r);
      chk_eq("zero bit slot", 2 * SP, lp[n0 + 3] - r);
      chk_eq("flp width", phl_pkg::FLP_WIDTH_CYC, dn[5] - up[5]);
      chk_eq("burst pulses", 20, lp.size() - n0);
      chk_eq("burst span", 16 * SP, lp[$] - r);
      $display("test fast link pulse done");
   endtask
   task automatic t_freeze();
      logic [12:0] snap;
      settle(1'b0);
      clk_en = 1'b0;
      line_frame = 1'b1;
      snap = {link_pulse, tx_line_en, tx_line_d, crs, rx_clk_stb, rx_dv, rxd};
      repeat (20) @(negedge clock);
      chk_eq("frozen outputs", snap, {link_pulse, tx_line_en, tx_line_d, crs, rx_clk_stb, rx_dv, rxd});
      line_frame = 1'b0;
      clk_en = 1'b1;
      $display("test clock enable done");
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clock);
      chk_eq("reset outputs", 0, {link_pulse, tx_line_en, tx_line_d, crs, rx_dv, rxd});
      resetn = 1'b1;
      t_rxclk();
      t_freeze();
      t_rx(1'b1);
      t_rx(1'b0);
      t_tx(1'b1);
      t_tx(1'b0);
      t_nlp();
      t_flp();
      complete_run();
   end
   initial begin
      repeat (99000) @(posedge clock);
      err_total++;
      complete_run();
   end
endmodule
